// >>> design/odc_pkg.sv
// package: register map, field layout, reset values and bus carriers
package odc_pkg;

    localparam logic [31:0] OFS_OSC_CTRL = 32'h0000_0000;
    localparam logic [31:0] OFS_UNLOCK = 32'h0000_0004;
    localparam logic [31:0] UNLOCK_KEY_A = 32'h5A5A_0001;
    localparam logic [31:0] UNLOCK_KEY_B = 32'hA5A5_0002;

    localparam int POS_PLL_ODIV = 27;
    localparam int POS_FRC_DIV = 24;
    localparam int POS_SOSC_RDY = 22;
    localparam int POS_PB_RDY = 21;
    localparam int POS_PB_DIV = 19;

    localparam logic [2:0] RST_FRC_DIV = 3'h1;
    localparam logic [2:0] CODE_DIV256 = 3'h7;
    localparam logic [7:0] LIMIT_DIV256 = 8'hFF;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef enum logic [1:0] {LK_LOCKED, LK_HALF, LK_OPEN} odc_lock_e;

    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic [31:0] hwdata;
        logic hready;
    } odc_ahb_req_s;

    typedef struct packed {
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
    } odc_ahb_rsp_s;

endpackage : odc_pkg

// >>> design/odc_divider.sv
// module: power-of-two tick divider that adopts a new code at period end
`timescale 1ns/10ps
module odc_divider
(
    input wire logic clk,
    input wire logic rst,
    input wire logic in_tick,
    input wire logic [2:0] code_req,
    output logic [2:0] code_act,
    output logic out_tick
);

    typedef struct packed {
        logic [7:0] cnt;
        logic [2:0] act;
        logic tick;
    } odc_div_s;

    odc_div_s st_r;
    odc_div_s st_nxt;

    function automatic logic [7:0] odc_limit(input logic [2:0] code);
        logic [7:0] one;
        one = 8'h01;
        if (code == odc_pkg::CODE_DIV256)
            return odc_pkg::LIMIT_DIV256;
        return 8'((one << code) - one);
    endfunction : odc_limit

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (in_tick)
        begin
            if (st_r.cnt >= odc_limit(st_r.act))
            begin
                st_nxt.cnt = 8'h00;
                st_nxt.tick = 1'b1;
                st_nxt.act = code_req;
            end
            else
            begin
                st_nxt.cnt = 8'(st_r.cnt + 8'h01);
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_r.cnt <= 8'h00;
            st_r.act <= code_req;
            st_r.tick <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign code_act = st_r.act;
    assign out_tick = st_r.tick;

endmodule : odc_divider

// >>> design/odc_top.sv
// module: oscillator control register with clock dividers and AHB-Lite slave
//
// Function
// - pll divider code 0-6 powers, 7=256
// - fast rc divider same map, reset 001
// - bit 22 shows secondary oscillator stable
// - bit 21 ready gates periph divisor writes
// - periph bus clock is system/1,2,4,8
// - control writes need a prior unlock sequence
// - bits 31:30 and 23 read zero
// - pll and periph divisor fields load from straps at reset, fast rc divider resets to 001
`timescale 1ns/10ps
module odc_top
(
    input wire logic CLK,
    input wire logic RST,
    input odc_pkg::odc_ahb_req_s AHB_REQ,
    output odc_pkg::odc_ahb_rsp_s AHB_RSP,
    input wire logic [2:0] CFG_PLL_ODIV,
    input wire logic [1:0] CFG_PB_DIV,
    input wire logic SOSC_STABLE,
    input wire logic PLL_TICK,
    input wire logic FRC_TICK,
    output logic PLL_DIV_TICK,
    output logic FRC_DIV_TICK,
    output logic PB_CLK_TICK
);

    typedef struct packed {
        odc_pkg::odc_lock_e lock;
        logic [2:0] pll_output_divider;
        logic [2:0] fast_rc_divider;
        logic [1:0] periph_bus_divisor;
        logic [2:0] sosc_sync;
        logic secondary_osc_ready;
        logic dp_valid;
        logic dp_write;
        logic [31:0] dp_addr;
        logic [31:0] rdata;
    } odc_state_s;

    odc_state_s st_r;
    odc_state_s st_nxt;
    logic [2:0] pb_code_act;
    logic periph_divisor_ready;
    logic [31:0] osc_read;
    logic addr_take;

    ////////////////////////////////////////////////////////////////////////////
    // dividers

    odc_divider u_pll_div
    (
        .clk(CLK),
        .rst(RST),
        .in_tick(PLL_TICK),
        .code_req(st_r.pll_output_divider),
        .code_act(),
        .out_tick(PLL_DIV_TICK)
    );

    odc_divider u_frc_div
    (
        .clk(CLK),
        .rst(RST),
        .in_tick(FRC_TICK),
        .code_req(st_r.fast_rc_divider),
        .code_act(),
        .out_tick(FRC_DIV_TICK)
    );

    // periph codes 0..3 map straight onto divide by 1,2,4,8
    odc_divider u_pb_div
    (
        .clk(CLK),
        .rst(RST),
        .in_tick(1'b1),
        .code_req({1'b0, st_r.periph_bus_divisor}),
        .code_act(pb_code_act),
        .out_tick(PB_CLK_TICK)
    );

    // ready once the divider runs the requested divisor
    assign periph_divisor_ready = (pb_code_act == {1'b0, st_r.periph_bus_divisor});

    ////////////////////////////////////////////////////////////////////////////
    // read image

    always_comb
    begin
        osc_read = 32'h0000_0000;
        osc_read[odc_pkg::POS_PLL_ODIV +: 3] = st_r.pll_output_divider;
        osc_read[odc_pkg::POS_FRC_DIV +: 3] = st_r.fast_rc_divider;
        osc_read[odc_pkg::POS_SOSC_RDY] = st_r.secondary_osc_ready;
        osc_read[odc_pkg::POS_PB_RDY] = periph_divisor_ready;
        osc_read[odc_pkg::POS_PB_DIV +: 2] = st_r.periph_bus_divisor;
    end

    assign addr_take = AHB_REQ.hsel && AHB_REQ.hready && (AHB_REQ.htrans == odc_pkg::HTRANS_NONSEQ);

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        st_nxt = st_r;

        // three-stage synchroniser, change once stages two and three agree
        st_nxt.sosc_sync = {st_r.sosc_sync[1:0], SOSC_STABLE};
        if (st_r.sosc_sync[1] == st_r.sosc_sync[2])
            st_nxt.secondary_osc_ready = st_r.sosc_sync[2];

        // address phase
        st_nxt.dp_valid = 1'b0;
        if (addr_take)
        begin
            st_nxt.dp_valid = 1'b1;
            st_nxt.dp_write = AHB_REQ.hwrite;
            st_nxt.dp_addr = {AHB_REQ.haddr[31:2], 2'b00};
            st_nxt.rdata = 32'h0000_0000;
            if (!AHB_REQ.hwrite)
            begin
                if ({AHB_REQ.haddr[31:2], 2'b00} == odc_pkg::OFS_OSC_CTRL)
                    st_nxt.rdata = osc_read;
                else if ({AHB_REQ.haddr[31:2], 2'b00} == odc_pkg::OFS_UNLOCK)
                    st_nxt.rdata = {31'h0000_0000, st_r.lock == odc_pkg::LK_OPEN};
            end
        end

        // data phase of a write
        if (st_r.dp_valid && st_r.dp_write)
        begin
            unique case (st_r.lock)
                odc_pkg::LK_LOCKED:
                begin
                    if (st_r.dp_addr == odc_pkg::OFS_UNLOCK && AHB_REQ.hwdata == odc_pkg::UNLOCK_KEY_A)
                        st_nxt.lock = odc_pkg::LK_HALF;
                end
                odc_pkg::LK_HALF:
                begin
                    // any other write breaks the sequence
                    if (st_r.dp_addr == odc_pkg::OFS_UNLOCK && AHB_REQ.hwdata == odc_pkg::UNLOCK_KEY_B)
                        st_nxt.lock = odc_pkg::LK_OPEN;
                    else
                        st_nxt.lock = odc_pkg::LK_LOCKED;
                end
                odc_pkg::LK_OPEN:
                begin
                    if (st_r.dp_addr == odc_pkg::OFS_UNLOCK)
                        st_nxt.lock = odc_pkg::LK_LOCKED;
                end
            endcase

            // locked or half-open writes drop silently
            if (st_r.dp_addr == odc_pkg::OFS_OSC_CTRL && st_r.lock == odc_pkg::LK_OPEN)
            begin
                st_nxt.pll_output_divider = AHB_REQ.hwdata[odc_pkg::POS_PLL_ODIV +: 3];
                st_nxt.fast_rc_divider = AHB_REQ.hwdata[odc_pkg::POS_FRC_DIV +: 3];
                if (periph_divisor_ready)
                    st_nxt.periph_bus_divisor = AHB_REQ.hwdata[odc_pkg::POS_PB_DIV +: 2];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            st_r.lock <= odc_pkg::LK_LOCKED;
            st_r.pll_output_divider <= CFG_PLL_ODIV;
            st_r.fast_rc_divider <= odc_pkg::RST_FRC_DIV;
            st_r.periph_bus_divisor <= CFG_PB_DIV;
            st_r.sosc_sync <= 3'h0;
            st_r.secondary_osc_ready <= 1'b0;
            st_r.dp_valid <= 1'b0;
            st_r.dp_write <= 1'b0;
            st_r.dp_addr <= 32'h0000_0000;
            st_r.rdata <= 32'h0000_0000;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus answer, zero wait states, always okay

    assign AHB_RSP.hrdata = st_r.rdata;
    assign AHB_RSP.hreadyout = 1'b1;
    assign AHB_RSP.hresp = 1'b0;

endmodule : odc_top

// >>> sim/odc_top_sva.sv
// checker: bus response and readback properties of the oscillator control block
`timescale 1ns/10ps
module odc_top_sva
(
    input wire logic CLK,
    input wire logic RST,
    input odc_pkg::odc_ahb_req_s AHB_REQ,
    input odc_pkg::odc_ahb_rsp_s AHB_RSP,
    input wire logic SOSC_STABLE,
    input wire logic PB_CLK_TICK
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    wire logic rd_acc = AHB_REQ.hsel && AHB_REQ.hready && !AHB_REQ.hwrite
        && AHB_REQ.htrans == odc_pkg::HTRANS_NONSEQ;
    wire logic rd_ctl = rd_acc && AHB_REQ.haddr[31:2] == 30'h0;
    wire [31:0] q = AHB_RSP.hrdata;
    ////////////////////////////////////////////////////////////////////////////////
    property p_okay; AHB_RSP.hreadyout && !AHB_RSP.hresp; endproperty
    a_okay: assert property (p_okay) else $error("bus not ready or error");
    property p_unm; rd_acc && AHB_REQ.haddr[31:3] != 29'h0 |=> q == 32'h0; endproperty
    a_unm: assert property (p_unm) else $error("unmapped read not zero");
    property p_rsv; rd_ctl |=> q[31:30] == 2'h0 && !q[23]; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits not zero");
    property p_low; rd_ctl |=> q[18:0] == 19'h0; endproperty
    a_low: assert property (p_low) else $error("low bits not zero");
    property p_key; rd_acc && AHB_REQ.haddr[31:2] == 30'h1 |=> q[31:1] == 31'h0; endproperty
    a_key: assert property (p_key) else $error("unlock readback wrong");
    property p_son; SOSC_STABLE [*8] ##0 rd_ctl |=> q[22]; endproperty
    a_son: assert property (p_son) else $error("osc ready not set");
    property p_soff; !SOSC_STABLE [*8] ##0 rd_ctl |=> !q[22]; endproperty
    a_soff: assert property (p_soff) else $error("osc ready not clear");
    property p_pb8; rd_ctl ##1 q[21:19] == 3'h7 |-> !(PB_CLK_TICK && $past(PB_CLK_TICK));
    endproperty
    a_pb8: assert property (p_pb8) else $error("bus tick too fast");
endmodule : odc_top_sva
bind odc_top odc_top_sva i_sva (.CLK(CLK), .RST(RST), .AHB_REQ(AHB_REQ), .AHB_RSP(AHB_RSP),
    .SOSC_STABLE(SOSC_STABLE), .PB_CLK_TICK(PB_CLK_TICK));

// >>> sim/oscillator_divider_control_tb_top.sv
// testbench: register, unlock, divider and status scenarios
`timescale 1ns/10ps
module oscillator_divider_control_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic sosc = 1'b0;
    odc_pkg::odc_ahb_req_s m = '0;
    odc_pkg::odc_ahb_req_s bus;
    odc_pkg::odc_ahb_rsp_s rsp;
    logic [2:0] cfg_pll = 3'h5;
    logic [1:0] cfg_pb = 2'h2;
    logic slow = 1'b0;
    logic ptk = 1'b1;
    wire logic [2:0] tk;
    logic [31:0] rd;
    int err_total = 0;
    int total_checks = 0;
    assign bus = {m[71:1], rsp.hreadyout};
    always #20 clk = ~clk;
    // source ticks: every cycle, or every other cycle while slow is set
    always @(posedge clk) ptk <= !slow || !ptk;
    odc_top i_dut (.CLK(clk), .RST(rst), .AHB_REQ(bus), .AHB_RSP(rsp), .CFG_PLL_ODIV(cfg_pll),
        .CFG_PB_DIV(cfg_pb), .SOSC_STABLE(sosc), .PLL_TICK(ptk), .FRC_TICK(ptk),
        .PLL_DIV_TICK(tk[0]), .FRC_DIV_TICK(tk[1]), .PB_CLK_TICK(tk[2]));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [31:0] ctl(logic [2:0] p, logic [2:0] f, logic [1:0] b, logic r);
        return {2'h0, p, f, 2'h0, r, b, 19'h0};
    endfunction : ctl
    task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        m <= '{1'b1, a, odc_pkg::HTRANS_NONSEQ, w, 3'h2, m.hwdata, 1'b0};
        do @(posedge clk); while (rsp.hreadyout !== 1'b1);
        m <= '{1'b0, a, 2'h0, w, 3'h2, d, 1'b0};
        do @(posedge clk); while (rsp.hreadyout !== 1'b1);
        rd = rsp.hrdata;
    endtask : xfer
    task automatic per(input int s, input int n);
        int c;
        repeat (2) do @(posedge clk); while (tk[s] !== 1'b1);
        c = 0;
        do
        begin
            @(posedge clk);
            c++;
        end while (tk[s] !== 1'b1);
        chk(c, n);
    endtask : per
    task automatic unlock;
        xfer(odc_pkg::OFS_UNLOCK, 1'b1, odc_pkg::UNLOCK_KEY_A);
        xfer(odc_pkg::OFS_UNLOCK, 1'b1, odc_pkg::UNLOCK_KEY_B);
    endtask : unlock
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        xfer(odc_pkg::OFS_OSC_CTRL, 1'b0, 32'h0);
        chk(rd, ctl(3'h5, odc_pkg::RST_FRC_DIV, 2'h2, 1'b1));
        per(0, 32);
        per(1, 2);
        per(2, 4);
        xfer(32'h0000_0008, 1'b0, 32'h0);
        chk(rd, 32'h0);
    endtask : t_reset
    task automatic t_locked;
        xfer(odc_pkg::OFS_OSC_CTRL, 1'b1, 32'h0);
        xfer(odc_pkg::OFS_OSC_CTRL, 1'b0, 32'h0);
        chk(rd, ctl(3'h5, 3'h1, 2'h2, 1'b1));
        unlock;
        xfer(odc_pkg::OFS_UNLOCK, 1'b0, 32'h0);
        chk(rd, 32'h1);
        xfer(odc_pkg::OFS_UNLOCK, 1'b1, 32'h0);
        xfer(odc_pkg::OFS_OSC_CTRL, 1'b1, 32'h0);
        xfer(odc_pkg::OFS_OSC_CTRL, 1'b0, 32'h0);
        chk(rd, ctl(3'h5, 3'h1, 2'h2, 1'b1));
    endtask : t_locked
    task automatic t_codes;
        logic [2:0] k;
        unlock;
        for (int c = 0; c < 8; c++)
        begin
            k = c[2:0];
            xfer(odc_pkg::OFS_OSC_CTRL, 1'b1, ctl(k, ~k, 2'h2, 1'b0) | 32'hC080_0000);
            xfer(odc_pkg::OFS_OSC_CTRL, 1'b0, 32'h0);
            chk(rd, ctl(k, ~k, 2'h2, 1'b1));
            per(0, (k == odc_pkg::CODE_DIV256) ? 256 : (1 << c));
            per(1, (k == 3'h0) ? 256 : (1 << (7 - c)));
        end
    endtask : t_codes
    task automatic t_gate;
        xfer(odc_pkg::OFS_OSC_CTRL, 1'b1, ctl(3'h5, 3'h1, 2'h3, 1'b0));
        repeat (12) @(posedge clk);
        xfer(odc_pkg::OFS_OSC_CTRL, 1'b0, 32'h0);
        chk(rd, ctl(3'h5, 3'h1, 2'h3, 1'b1));
        per(2, 8);
        do @(posedge clk); while (tk[2] !== 1'b1);
        xfer(odc_pkg::OFS_OSC_CTRL, 1'b1, ctl(3'h5, 3'h1, 2'h0, 1'b0));
        xfer(odc_pkg::OFS_OSC_CTRL, 1'b1, ctl(3'h5, 3'h1, 2'h1, 1'b0));
        repeat (12) @(posedge clk);
        xfer(odc_pkg::OFS_OSC_CTRL, 1'b0, 32'h0);
        chk(rd, ctl(3'h5, 3'h1, 2'h0, 1'b1));
        per(2, 1);
    endtask : t_gate
    task automatic t_sosc;
        sosc <= 1'b1;
        repeat (8) @(posedge clk);
        xfer(odc_pkg::OFS_OSC_CTRL, 1'b0, 32'h0);
        chk(rd[22], 1'b1);
        sosc <= 1'b0;
        repeat (8) @(posedge clk);
        xfer(odc_pkg::OFS_OSC_CTRL, 1'b0, 32'h0);
        chk(rd[22], 1'b0);
    endtask : t_sosc
    task automatic t_rerst;
        cfg_pll <= 3'h2;
        cfg_pb <= 2'h1;
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        xfer(odc_pkg::OFS_OSC_CTRL, 1'b0, 32'h0);
        chk(rd, ctl(3'h2, odc_pkg::RST_FRC_DIV, 2'h1, 1'b1));
        per(2, 2);
        slow <= 1'b1;
        per(0, 8);
        per(1, 4);
        slow <= 1'b0;
        xfer(odc_pkg::OFS_OSC_CTRL, 1'b1, 32'h0);
        xfer(odc_pkg::OFS_OSC_CTRL, 1'b0, 32'h0);
        chk(rd, ctl(3'h2, odc_pkg::RST_FRC_DIV, 2'h1, 1'b1));
    endtask : t_rerst
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_locked;
        t_codes;
        t_gate;
        t_sosc;
        t_rerst;
        report_and_stop;
    end
    initial
    begin
        #800000;
        err_total++;
        report_and_stop;
    end
endmodule : oscillator_divider_control_tb_top
